// >>> hdl/asfi_pkg.sv
// Shared constants, types and format decoding for the async serial channel
package asfi_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_DIV = 8'h08;
    localparam logic [7:0] OFF_TXD = 8'h0C;
    localparam logic [7:0] OFF_RXD = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_IRC = 8'h18;
    // serial_mode_reg fields
    localparam int MODE_SYNC = 7;
    localparam int MODE_CHR = 6;
    localparam int MODE_PE = 5;
    localparam int MODE_ODD = 4;
    localparam int MODE_STOP2 = 3;
    localparam int MODE_FIVE = 2;
    // serial_control_reg fields
    localparam int CTRL_TE = 5;
    localparam int CTRL_RE = 4;
    localparam logic [1:0] CKE_PORT = 2'h0;
    localparam logic [1:0] CKE_OUT = 2'h1;
    localparam logic [1:0] CKE_EXT = 2'h2;
    // Status fields
    localparam int STAT_TDRE = 7;
    localparam int STAT_RDRF = 6;
    localparam int STAT_OER = 5;
    localparam int STAT_FER = 4;
    localparam int STAT_PER = 3;
    localparam int STAT_TEND = 2;
    // infrared_control fields
    localparam int IRC_EN = 7;
    localparam logic [7:0] IRC_WMASK = 8'hF0;
    localparam logic [2:0] IR_SEL_3_16 = 3'h0;
    localparam logic [2:0] IR_SEL_DIV8 = 3'h3;
    localparam logic [2:0] IR_SEL_DIV16 = 3'h4;
    localparam logic [4:0] IR_W_TICKS = 5'h03;
    localparam logic [4:0] IR_W_DIV8 = 5'h08;
    localparam logic [4:0] IR_W_DIV16 = 5'h10;
    localparam logic [4:0] IR_STRETCH = 5'h0C;
    // Reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] IRC_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0043;
    // 16x sample phases
    localparam logic [3:0] SAMPLE_PHASE = 4'h7;
    localparam logic [3:0] LAST_PHASE = 4'hF;
    localparam logic [3:0] CLK_RISE_PHASE = 4'h8;

    typedef struct packed {
        logic [3:0] nbits;
        logic par;
    } asfi_fmt_t;

    function automatic asfi_fmt_t asfi_fmt(input logic [7:0] mode);
        asfi_fmt_t f;
        f.par = mode[MODE_PE];
        f.nbits = mode[MODE_CHR] ? 4'h7 : 4'h8;
        // Five-bit select without parity is prohibited and falls back to 8/7 bits
        if (mode[MODE_FIVE] && mode[MODE_PE]) begin
            f.nbits = 4'h5;
            f.par = mode[MODE_CHR];
        end
        return f;
    endfunction
endpackage

// >>> hdl/asfi_rx_if.sv
// Link between the channel core and its receiver
`timescale 1ns/1ps
interface asfi_rx_if;
    logic tick;
    logic line;
    logic en;
    logic odd;
    asfi_pkg::asfi_fmt_t fmt;
    logic done;
    logic [7:0] data;
    logic perr;
    logic ferr;
    modport ctl (output tick, output line, output en, output odd, output fmt,
        input done, input data, input perr, input ferr);
    modport rx (input tick, input line, input en, input odd, input fmt,
        output done, output data, output perr, output ferr);
endinterface

// >>> hdl/asfi_rx.sv
// 16x oversampling asynchronous receiver
`timescale 1ns/1ps
module asfi_rx (
    input wire logic clock,
    input wire logic sys_rst,
    asfi_rx_if.rx rif
);
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asfi_rx_st_t;
    asfi_rx_st_t state_r;
    logic line_prev_r;
    logic [3:0] ph_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic par_r;
    logic done_r;
    logic [7:0] data_r;
    logic perr_r;
    logic ferr_r;
    logic fall;
    logic smp;

    assign fall = rif.tick && line_prev_r && !rif.line;
    assign smp = rif.tick && (ph_r == asfi_pkg::SAMPLE_PHASE);
    assign rif.done = done_r;
    assign rif.data = data_r;
    assign rif.perr = perr_r;
    assign rif.ferr = ferr_r;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            line_prev_r <= 1'b1;
            ph_r <= 4'h0;
        end else if (rif.tick) begin
            line_prev_r <= rif.line;
            // Phase restarts at each start edge so sampling lands mid-bit
            ph_r <= (state_r == RX_IDLE && fall) ? 4'h0 : ph_r + 4'h1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= RX_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            par_r <= 1'b0;
            done_r <= 1'b0;
            data_r <= 8'h00;
            perr_r <= 1'b0;
            ferr_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                RX_IDLE: begin
                    if (rif.en && fall) begin
                        state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (smp) begin
                        // A start bit that is high again at its centre was a glitch
                        state_r <= rif.line ? RX_IDLE : RX_DATA;
                        cnt_r <= 4'h0;
                        par_r <= 1'b0;
                        perr_r <= 1'b0;
                    end
                end
                RX_DATA: begin
                    if (smp) begin
                        sh_r <= {rif.line, sh_r[7:1]};
                        par_r <= par_r ^ rif.line;
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r + 4'h1 == rif.fmt.nbits) begin
                            state_r <= rif.fmt.par ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (smp) begin
                        perr_r <= par_r ^ rif.line ^ rif.odd;
                        state_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (smp) begin
                        // Only the first stop bit is judged; a second one is idle line
                        ferr_r <= !rif.line;
                        data_r <= sh_r >> (4'h8 - rif.fmt.nbits);
                        done_r <= 1'b1;
                        state_r <= RX_IDLE;
                    end
                end
                default: state_r <= RX_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    rx_start_sync_a: assert property (
        state_r == RX_IDLE && rif.en && fall |=> state_r == RX_START && ph_r == 4'h0)
        else $error("receiver did not lock to start edge");
    rx_center_sample_a: assert property (
        state_r == RX_START && rif.tick && ph_r == 4'h7 && !rif.line |=> state_r == RX_DATA)
        else $error("start bit not taken at eighth pulse");
    rx_stop_check_a: assert property (
        state_r == RX_STOP && smp |=> done_r && ferr_r == !$past(rif.line) ##1 !done_r)
        else $error("stop bit check wrong");
endmodule

// >>> hdl/asfi_top.sv
// Async serial channel with infrared encoding, AHB-Lite register slave
`timescale 1ns/1ps
module asfi_top (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    input wire logic serial_clock_pin_a_i,
    output logic serial_clock_pin_a_o,
    output logic serial_clock_pin_a_oe
);
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asfi_tx_st_t;

    asfi_rx_if rif ();

    logic [7:0] mode_r, ctrl_r, irc_r, tdr_r, rdr_r, rd_val, tx_sh_r;
    logic [15:0] div_r, div_cnt_r;
    logic [31:0] hrdata_r;
    logic [7:0] wr_addr_r;
    logic wr_pend_r, hreadyout_r, hresp_r, addr_ph, mapped, rxd_read;
    logic tdr_full_r, rdr_full_r, oer_r, fer_r, per_r;
    logic sck_s1_r, sck_s2_r, sck_prev_r, rx_s1_r, rx_s2_r, rx_prev_r;
    logic tick_r, tick_d_r, bnd, tx_take, tx_bit_r, tx_par_r, tx_stop2_r, bstart_r;
    logic [3:0] tx_ph_r, tx_cnt_r;
    logic [4:0] ir_left_r, ir_width, stretch_r;
    logic ir_en, ir_by_tick, ir_sel_ok, tx_pin_r, sck_o_r, sck_oe_r;
    logic [2:0] ir_sel;
    asfi_tx_st_t tx_state_r;
    asfi_pkg::asfi_fmt_t fmt;

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign serial_tx_pin = tx_pin_r;
    assign serial_clock_pin_a_o = sck_o_r;
    assign serial_clock_pin_a_oe = sck_oe_r;

    assign fmt = asfi_pkg::asfi_fmt(mode_r);
    assign ir_en = irc_r[asfi_pkg::IRC_EN];
    assign ir_sel = irc_r[6:4];

    // Bus slave: zero wait states, read data fetched at the address phase
    assign addr_ph = hsel && htrans[1] && hready;
    assign mapped = (haddr[31:8] == 24'h00_0000);
    assign rxd_read = addr_ph && !hwrite && mapped && (haddr[7:0] == asfi_pkg::OFF_RXD);

    always_comb begin
        case (haddr[7:0])
            asfi_pkg::OFF_MODE: rd_val = mode_r;
            asfi_pkg::OFF_CTRL: rd_val = ctrl_r;
            asfi_pkg::OFF_DIV: rd_val = div_r[7:0];
            asfi_pkg::OFF_RXD: rd_val = rdr_r;
            asfi_pkg::OFF_STAT: rd_val = {!tdr_full_r, rdr_full_r, oer_r, fer_r, per_r,
                tx_state_r == TX_IDLE && !tdr_full_r, 2'h0};
            asfi_pkg::OFF_IRC: rd_val = irc_r;
            default: rd_val = 8'h00;
        endcase
        if (!mapped) begin
            rd_val = 8'h00;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            wr_pend_r <= addr_ph && hwrite && mapped;
            if (addr_ph) begin
                wr_addr_r <= haddr[7:0];
            end
            if (addr_ph && !hwrite) begin
                hrdata_r <= {24'h00_0000, rd_val};
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= asfi_pkg::MODE_RST;
            ctrl_r <= asfi_pkg::CTRL_RST;
            div_r <= asfi_pkg::DIV_RST;
            irc_r <= asfi_pkg::IRC_RST;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                asfi_pkg::OFF_MODE: mode_r <= hwdata[7:0];
                asfi_pkg::OFF_CTRL: ctrl_r <= hwdata[7:0];
                asfi_pkg::OFF_DIV: div_r <= hwdata[15:0];
                asfi_pkg::OFF_IRC: irc_r <= hwdata[7:0] & asfi_pkg::IRC_WMASK;
                default: ;
            endcase
        end
    end

    // Pin synchronisers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_prev_r <= 1'b0;
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            sck_s1_r <= serial_clock_pin_a_i;
            sck_s2_r <= sck_s1_r;
            sck_prev_r <= sck_s2_r;
            rx_s1_r <= serial_rx_pin;
            rx_s2_r <= rx_s1_r;
            rx_prev_r <= rx_s2_r;
        end
    end

    // 16x tick from the baud divider or from the external clock pin
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else if (ctrl_r[1:0] == asfi_pkg::CKE_EXT) begin
            div_cnt_r <= 16'h0000;
            // The partner must clock this pin at 16x the bit rate
            tick_r <= sck_s2_r && !sck_prev_r;
        end else begin
            div_cnt_r <= (div_cnt_r >= div_r) ? 16'h0000 : div_cnt_r + 16'h0001;
            tick_r <= (div_cnt_r >= div_r);
        end
    end

    // Clock pin drive; rising edge at phase 8 marks mid-bit
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sck_o_r <= 1'b0;
            sck_oe_r <= 1'b0;
        end else begin
            sck_o_r <= tx_ph_r[3];
            sck_oe_r <= !mode_r[asfi_pkg::MODE_SYNC] && ctrl_r[1:0] == asfi_pkg::CKE_OUT;
        end
    end

    // Transmitter, independent of the receiver
    assign bnd = tick_r && (tx_ph_r == asfi_pkg::LAST_PHASE);
    assign tx_take = bnd && tdr_full_r && ctrl_r[asfi_pkg::CTRL_TE]
        && (tx_state_r == TX_IDLE || (tx_state_r == TX_STOP && !tx_stop2_r));

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tdr_r <= 8'h00;
            tdr_full_r <= 1'b0;
        end else begin
            if (wr_pend_r && wr_addr_r == asfi_pkg::OFF_TXD) begin
                tdr_r <= hwdata[7:0];
                tdr_full_r <= 1'b1;
            end else if (tx_take) begin
                tdr_full_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state_r <= TX_IDLE;
            tx_ph_r <= 4'h0;
            tx_cnt_r <= 4'h0;
            tx_sh_r <= 8'h00;
            tx_bit_r <= 1'b1;
            tx_par_r <= 1'b0;
            tx_stop2_r <= 1'b0;
        end else begin
            if (tick_r) begin
                tx_ph_r <= tx_ph_r + 4'h1;
            end
            if (tx_take) begin
                tx_sh_r <= tdr_r;
                tx_bit_r <= 1'b0;
                tx_state_r <= TX_START;
            end else if (bnd) begin
                case (tx_state_r)
                    TX_IDLE: tx_bit_r <= 1'b1;
                    TX_START, TX_DATA: begin
                        if (tx_state_r == TX_DATA && tx_cnt_r == fmt.nbits) begin
                            tx_bit_r <= fmt.par ? tx_par_r ^ mode_r[asfi_pkg::MODE_ODD] : 1'b1;
                            tx_state_r <= fmt.par ? TX_PAR : TX_STOP;
                            tx_stop2_r <= mode_r[asfi_pkg::MODE_STOP2];
                        end else begin
                            tx_bit_r <= tx_sh_r[0];
                            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                            tx_par_r <= (tx_state_r == TX_START) ? tx_sh_r[0] : tx_par_r ^ tx_sh_r[0];
                            tx_cnt_r <= (tx_state_r == TX_START) ? 4'h1 : tx_cnt_r + 4'h1;
                            tx_state_r <= TX_DATA;
                        end
                    end
                    TX_PAR: begin
                        tx_bit_r <= 1'b1;
                        tx_state_r <= TX_STOP;
                    end
                    TX_STOP: begin
                        tx_bit_r <= 1'b1;
                        if (tx_stop2_r) begin
                            tx_stop2_r <= 1'b0;
                        end else begin
                            tx_state_r <= TX_IDLE;
                        end
                    end
                    default: tx_state_r <= TX_IDLE;
                endcase
            end
        end
    end

    // Infrared transmit pulse; unknown or prohibited codes emit no pulse
    always_comb begin
        ir_by_tick = 1'b0;
        ir_sel_ok = 1'b1;
        case (ir_sel)
            asfi_pkg::IR_SEL_3_16: begin
                ir_width = asfi_pkg::IR_W_TICKS;
                ir_by_tick = 1'b1;
            end
            asfi_pkg::IR_SEL_DIV8: ir_width = asfi_pkg::IR_W_DIV8;
            asfi_pkg::IR_SEL_DIV16: ir_width = asfi_pkg::IR_W_DIV16;
            default: begin
                ir_width = 5'h00;
                ir_sel_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bstart_r <= 1'b0;
            tick_d_r <= 1'b0;
            ir_left_r <= 5'h00;
            tx_pin_r <= 1'b1;
        end else begin
            bstart_r <= bnd || tx_take;
            tick_d_r <= tick_r;
            if (!ir_en) begin
                ir_left_r <= 5'h00;
            end else if (bstart_r && !tx_bit_r) begin
                ir_left_r <= ir_width;
            // Load lags the boundary tick by one clock; the delayed tick keeps whole tick periods
            end else if (ir_left_r != 5'h00 && (tick_d_r || !ir_by_tick)) begin
                ir_left_r <= ir_left_r - 5'h01;
            end
            tx_pin_r <= ir_en ? (ir_left_r != 5'h00) : tx_bit_r;
        end
    end

    // Infrared receive: a high pulse is stretched into a low bit for the receiver
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stretch_r <= 5'h00;
        end else if (ir_en && rx_s2_r && !rx_prev_r) begin
            stretch_r <= asfi_pkg::IR_STRETCH;
        end else if (tick_r && stretch_r != 5'h00) begin
            stretch_r <= stretch_r - 5'h01;
        end
    end

    assign rif.tick = tick_r;
    assign rif.line = ir_en ? (stretch_r == 5'h00) : rx_s2_r;
    assign rif.en = ctrl_r[asfi_pkg::CTRL_RE];
    assign rif.odd = mode_r[asfi_pkg::MODE_ODD];
    assign rif.fmt = fmt;

    asfi_rx u_rx (
        .clock(clock),
        .sys_rst(sys_rst),
        .rif(rif)
    );

    // Receive buffer; a new frame while full is lost as overrun
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdr_r <= 8'h00;
            rdr_full_r <= 1'b0;
            oer_r <= 1'b0;
            fer_r <= 1'b0;
            per_r <= 1'b0;
        end else begin
            if (wr_pend_r && wr_addr_r == asfi_pkg::OFF_STAT) begin
                oer_r <= oer_r && !hwdata[asfi_pkg::STAT_OER];
                fer_r <= fer_r && !hwdata[asfi_pkg::STAT_FER];
                per_r <= per_r && !hwdata[asfi_pkg::STAT_PER];
            end
            if (rxd_read) begin
                rdr_full_r <= 1'b0;
            end
            if (rif.done && rif.en) begin
                if (rdr_full_r) begin
                    oer_r <= 1'b1;
                end else begin
                    rdr_r <= rif.data;
                    rdr_full_r <= 1'b1;
                    fer_r <= fer_r || rif.ferr;
                    per_r <= per_r || rif.perr;
                end
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_ir_load_div8;
        ir_en && bstart_r && !tx_bit_r && ir_sel == asfi_pkg::IR_SEL_DIV8;
    endsequence
    sequence s_pulse_8;
        (ir_left_r != 5'h00)[*8] ##1 (ir_left_r == 5'h00);
    endsequence

    tx_start_low_a: assert property (
        tx_take && !(wr_pend_r && wr_addr_r == asfi_pkg::OFF_TXD)
        |=> tx_state_r == TX_START && !tx_bit_r && !tdr_full_r)
        else $error("start bit not sent on load");
    ir_div8_width_a: assert property (s_ir_load_div8 |=> s_pulse_8)
        else $error("infrared pulse width wrong");
    ir_one_quiet_a: assert property (
        ir_en && bstart_r && tx_bit_r && ir_left_r == 5'h00 |=> ir_left_r == 5'h00)
        else $error("pulse sent for a one bit");
    ir_bad_code_a: assert property ((ir_en && !ir_sel_ok)[*3] |-> !tx_pin_r)
        else $error("pulse on undefined width code");
    plain_pin_a: assert property (
        $past(!ir_en) |-> tx_pin_r == $past(tx_bit_r))
        else $error("plain mode pin does not follow data");
    ir_reserved_a: assert property (irc_r[3:0] == 4'h0)
        else $error("reserved infrared bits not zero");
    clk_mid_bit_a: assert property (
        $rose(sck_o_r) |-> $past(tx_ph_r) == asfi_pkg::CLK_RISE_PHASE)
        else $error("clock output edge not mid-bit");
    rx_overrun_a: assert property (
        rif.done && rif.en && rdr_full_r && !rxd_read |=> oer_r && rdr_full_r && $stable(rdr_r))
        else $error("overrun overwrote receive buffer");
endmodule

// >>> tb/asfi_peer.sv
// Remote serial device model: sends and captures plain asynchronous frames
`timescale 1ns/1ps
module asfi_peer #(
    parameter int BIT_CLKS = 32
) (
    input wire logic clock,
    input wire logic from_dev,
    output logic to_dev
);
    int nb = 8;
    logic par = 1'b0;
    logic odd = 1'b0;
    logic two = 1'b0;
    int bad = 0;
    logic [7:0] got = 8'h00;
    int n_got = 0;
    initial to_dev = 1'b1;
    task automatic put(input logic v);
        @(posedge clock);
        to_dev <= v;
        repeat (BIT_CLKS - 1) @(posedge clock);
    endtask
    // Bad 1 flips parity, bad 2 drives the first stop bit low
    task automatic send(input logic [7:0] d);
        put(1'b0);
        for (int i = 0; i < nb; i++) put(d[i]);
        if (par) put(^(d & (8'hFF >> (8 - nb))) ^ odd ^ (bad == 1));
        put(bad != 2);
        if (two) put(1'b1);
    endtask
    // Centre sampling keeps the capture tolerant of a clock or two of skew
    always begin
        @(negedge from_dev);
        repeat (BIT_CLKS / 2) @(posedge clock);
        got = 8'h00;
        for (int i = 0; i < nb; i++) begin
            repeat (BIT_CLKS) @(posedge clock);
            got[i] = from_dev;
        end
        repeat (par ? 2 * BIT_CLKS : BIT_CLKS) @(posedge clock);
        n_got++;
    end
endmodule

// >>> tb/async_serial_frame_infrared_tb.sv
// Self-checking bench for the async serial channel
`timescale 1ns/1ps
module async_serial_frame_infrared_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [2:0] hsize = 3'h2;
    logic ck_in = 1'b0;
    logic ck_o;
    logic rx_pin;
    logic tx_pin;
    logic ck_oe;
    logic [31:0] q;
    logic [7:0] m;
    logic [7:0] mk;
    int failures = 0;
    int n_checks = 0;
    int w;
    logic [7:0] modes [7] = '{8'h00, 8'h40, 8'h20, 8'h64, 8'h24, 8'h38, 8'h70};
    logic [7:0] irc [4] = '{8'h80, 8'hB0, 8'hC0, 8'h90};
    int pw [4] = '{6, 8, 16, 0};
    asfi_top uut (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .serial_rx_pin(rx_pin), .serial_tx_pin(tx_pin),
        .serial_clock_pin_a_i(ck_in), .serial_clock_pin_a_o(ck_o), .serial_clock_pin_a_oe(ck_oe));
    asfi_peer #(.BIT_CLKS(32)) peer (.clock(clock), .from_dev(tx_pin), .to_dev(rx_pin));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
        chk("hresp", 32'(hresp), '0);
        @(posedge clock);
    endtask
    task automatic rxc(input logic [7:0] st, input logic [7:0] d);
        bus(asfi_pkg::OFF_STAT, 1'b0, '0);
        chk("status", q & 32'h0000_0078, {24'h00_0000, st});
        bus(asfi_pkg::OFF_STAT, 1'b1, 32'h0000_0038);
        bus(asfi_pkg::OFF_RXD, 1'b0, '0);
        chk("rx data", q, {24'h00_0000, d});
    endtask
    task automatic stop_test;
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        forever #4 clock = ~clock;
    end
    // Free-running external clock at 16x the peer's bit rate
    always @(posedge clock) ck_in <= ~ck_in;
    // A full run takes about 9000 cycles
    initial begin
        #400000;
        failures++;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        bus(asfi_pkg::OFF_IRC, 1'b0, '0);
        chk("ir reset", q, '0);
        // Enable bit left clear so the transmit pin stays plain for the frame tests
        bus(asfi_pkg::OFF_IRC, 1'b1, 32'h0000_007F);
        bus(asfi_pkg::OFF_IRC, 1'b0, '0);
        chk("ir mask", q, 32'h0000_0070);
        bus(8'h40, 1'b0, '0);
        chk("unmapped", q, '0);
        bus(asfi_pkg::OFF_DIV, 1'b1, 32'h0000_0001);
        bus(asfi_pkg::OFF_CTRL, 1'b1, 32'h0000_0031);
        @(posedge clock);
        chk("clock oe on", 32'(ck_oe), 32'h0000_0001);
        w = 0;
        while (ck_o !== 1'b1 && w < 100) begin
            @(posedge clock);
            w++;
        end
        chk("clock out", 32'(ck_o), 32'h0000_0001);
        for (int i = 0; i < 7; i++) begin
            m = modes[i];
            peer.nb = (m[2] & m[5]) ? 5 : (m[6] ? 7 : 8);
            peer.par = (m[2] & m[5]) ? m[6] : m[5];
            peer.odd = m[4];
            peer.two = m[3];
            mk = 8'hFF >> (8 - peer.nb);
            w = peer.n_got;
            bus(asfi_pkg::OFF_MODE, 1'b1, {24'h00_0000, m});
            fork
                bus(asfi_pkg::OFF_TXD, 1'b1, {24'h00_0000, 8'hA5 ^ 8'(i)});
                peer.send(8'h3C + 8'(i));
            join
            repeat (400) @(posedge clock);
            chk("peer count", 32'(peer.n_got), 32'(w + 1));
            chk("peer data", 32'(peer.got), 32'((8'hA5 ^ 8'(i)) & mk));
            rxc(8'h40, (8'h3C + 8'(i)) & mk);
        end
        peer.nb = 8;
        peer.par = 1'b1;
        peer.odd = 1'b0;
        peer.two = 1'b0;
        peer.bad = 1;
        bus(asfi_pkg::OFF_MODE, 1'b1, 32'h0000_0020);
        peer.send(8'h5A);
        rxc(8'h48, 8'h5A);
        peer.par = 1'b0;
        peer.two = 1'b1;
        peer.bad = 2;
        bus(asfi_pkg::OFF_MODE, 1'b1, 32'h0000_0008);
        peer.send(8'h81);
        rxc(8'h50, 8'h81);
        peer.two = 1'b0;
        peer.bad = 0;
        bus(asfi_pkg::OFF_MODE, 1'b1, '0);
        peer.send(8'h55);
        peer.send(8'h66);
        rxc(8'h60, 8'h55);
        bus(asfi_pkg::OFF_CTRL, 1'b1, 32'h0000_0032);
        peer.send(8'hC3);
        rxc(8'h40, 8'hC3);
        bus(asfi_pkg::OFF_CTRL, 1'b1, 32'h0000_0030);
        @(posedge clock);
        chk("clock oe off", 32'(ck_oe), '0);
        for (int i = 0; i < 4; i++) begin
            bus(asfi_pkg::OFF_IRC, 1'b1, {24'h00_0000, irc[i]});
            bus(asfi_pkg::OFF_TXD, 1'b1, '0);
            w = 0;
            for (int k = 0; k < 200 && tx_pin !== 1'b1; k++) @(posedge clock);
            while (tx_pin === 1'b1 && w < 100) begin
                @(posedge clock);
                w++;
            end
            chk("ir pulse", 32'(w), 32'(pw[i]));
            repeat (400) @(posedge clock);
            chk("ir idle", 32'(tx_pin), '0);
        end
        stop_test;
    end
endmodule
